// ### reset_combiner_pkg.sv
// Purpose: constants and types for the reset source combiner
// Assumes: apb slave, 32-bit data, word aligned registers
// Notes: bit 0 of every source vector is the power-on source
package reset_combiner_pkg;
	localparam int NUM_SRC = 7;
	localparam int ADDR_W = 12;
	localparam logic [ADDR_W-1:0] CAUSE_OFS = 12'h000;
	localparam logic [ADDR_W-1:0] EVT_STATUS_OFS = 12'h004;
	localparam logic [ADDR_W-1:0] EVT_MASK_OFS = 12'h008;
	localparam logic [ADDR_W-1:0] LIVE_REQ_OFS = 12'h00C;
	localparam logic [ADDR_W-1:0] SENS_SCRATCH_OFS = 12'h010;
	localparam logic [ADDR_W-1:0] KEEP_SCRATCH_OFS = 12'h014;
	localparam int POR_BIT = 0;
	localparam logic [NUM_SRC-1:0] CAUSE_RST = 7'h01;
	localparam logic [NUM_SRC-1:0] MASK_RST = 7'h00;
	localparam logic [31:0] SCRATCH_RST = 32'h0000_0000;

	// one bit per reset source, power-on in bit 0
	typedef struct packed {
		logic illegalOpcodeUninitRegReset;
		logic trapConflictReset;
		logic watchdogReset;
		logic softwareInstructionReset;
		logic externalClearPinReset;
		logic brownOutReset;
		logic powerOnReset;
	} resetReq_s;

	// on-chip requests that arrive on the local clock
	typedef struct packed {
		logic illegalOpcodeUninitRegReset;
		logic trapConflictReset;
		logic watchdogReset;
		logic softwareInstructionReset;
		logic brownOutReset;
		logic powerOnReset;
	} onchipReq_s;
endpackage : reset_combiner_pkg

// ### reset_source_combiner.sv
// Purpose: combine seven reset requests into the master system reset
// Assumes: on-chip requests are synchronous to ref_clk, pin is not
// Notes: cause register survives every reset except rst_n and the power-on source
//
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none
module reset_source_combiner
	import reset_combiner_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// reset sources
	input wire onchipReq_s onchipReq,
	input wire logic externalClearPin_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// results
	output logic masterSystemReset,
	output logic resetIrq
);
	logic [2:0] pinSync_q;
	logic pinActive_q;
	resetReq_s reqVec;
	logic masterSystemReset_q;
	logic [NUM_SRC-1:0] cause_q;
	logic [NUM_SRC-1:0] prevReq_q;
	logic [NUM_SRC-1:0] evtStatus_q;
	logic [NUM_SRC-1:0] evtMask_q;
	logic [31:0] sensScratch_q;
	logic [31:0] keepScratch_q;
	logic resetIrq_q;
	logic pready_q;
	logic pslverr_q;
	logic [31:0] prdata_q;
	logic [31:0] rdData;
	logic addrHit;
	logic busDone;
	logic wrCause;
	logic wrStatus;
	logic wrMask;
	logic wrSens;
	logic wrKeep;
	logic [NUM_SRC-1:0] onsetVec;
	logic resetLive_q;

	function automatic logic [31:0] strbMerge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] st);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				res[8*i +: 8] = wd[8*i +: 8];
			end
		end
		return res;
	endfunction : strbMerge

	// pin: three stages, level changes once stages two and three agree
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pinSync_q <= 3'h0;
			pinActive_q <= 1'b0;
		end else begin
			pinSync_q <= {pinSync_q[1:0], ~externalClearPin_n};
			if (pinSync_q[1] == pinSync_q[2]) begin
				pinActive_q <= pinSync_q[2];
			end
		end
	end

	// gather all seven sources
	always_comb begin
		reqVec.powerOnReset = onchipReq.powerOnReset;
		reqVec.brownOutReset = onchipReq.brownOutReset;
		reqVec.externalClearPinReset = pinActive_q;
		reqVec.softwareInstructionReset = onchipReq.softwareInstructionReset;
		reqVec.watchdogReset = onchipReq.watchdogReset;
		reqVec.trapConflictReset = onchipReq.trapConflictReset;
		reqVec.illegalOpcodeUninitRegReset = onchipReq.illegalOpcodeUninitRegReset;
	end

	// master reset depends on sources only, never on bus writes
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			masterSystemReset_q <= 1'b1;
		end else begin
			masterSystemReset_q <= |reqVec;
		end
	end

	// apb decode
	assign busDone = psel & penable & pready_q;
	always_comb begin
		addrHit = 1'b1;
		rdData = 32'h0000_0000;
		case (paddr)
			CAUSE_OFS: rdData[NUM_SRC-1:0] = cause_q;
			EVT_STATUS_OFS: rdData[NUM_SRC-1:0] = evtStatus_q;
			EVT_MASK_OFS: rdData[NUM_SRC-1:0] = evtMask_q;
			LIVE_REQ_OFS: rdData[NUM_SRC-1:0] = reqVec;
			SENS_SCRATCH_OFS: rdData = sensScratch_q;
			KEEP_SCRATCH_OFS: rdData = keepScratch_q;
			default: addrHit = 1'b0;
		endcase
	end
	assign wrCause = busDone & pwrite & (paddr == CAUSE_OFS) & pstrb[0];
	assign wrStatus = busDone & pwrite & (paddr == EVT_STATUS_OFS) & pstrb[0];
	assign wrMask = busDone & pwrite & (paddr == EVT_MASK_OFS) & pstrb[0];
	assign wrSens = busDone & pwrite & (paddr == SENS_SCRATCH_OFS);
	assign wrKeep = busDone & pwrite & (paddr == KEEP_SCRATCH_OFS);

	// answer on the second access cycle
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else begin
			pready_q <= psel & penable & ~pready_q;
			pslverr_q <= psel & penable & ~pready_q & ~addrHit;
			if (psel & penable & ~pready_q & ~pwrite) begin
				prdata_q <= rdData;
			end
		end
	end

	// cause flags: sources win over software, power-on wins over all
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cause_q <= CAUSE_RST;
		end else if (reqVec.powerOnReset) begin
			cause_q <= CAUSE_RST;
		end else if (wrCause) begin
			cause_q <= pwdata[NUM_SRC-1:0] | reqVec;
		end else begin
			cause_q <= cause_q | reqVec;
		end
	end

	// event flags: set on request onset, write one to clear, set wins
	assign onsetVec = reqVec & ~prevReq_q;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			prevReq_q <= 7'h00;
			evtStatus_q <= 7'h00;
			evtMask_q <= MASK_RST;
			resetIrq_q <= 1'b0;
		end else begin
			prevReq_q <= reqVec;
			evtStatus_q <= (evtStatus_q & ~(wrStatus ? pwdata[NUM_SRC-1:0] : 7'h00))
				| onsetVec;
			if (wrMask) begin
				evtMask_q <= pwdata[NUM_SRC-1:0];
			end
			resetIrq_q <= |(evtStatus_q & evtMask_q);
		end
	end

	// reset-sensitive scratch
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sensScratch_q <= SCRATCH_RST;
		end else if (masterSystemReset_q) begin
			sensScratch_q <= SCRATCH_RST;
		end else if (wrSens) begin
			sensScratch_q <= strbMerge(sensScratch_q, pwdata, pstrb);
		end
	end

	// retained scratch, untouched by the master reset
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			keepScratch_q <= SCRATCH_RST;
		end else if (wrKeep) begin
			keepScratch_q <= strbMerge(keepScratch_q, pwdata, pstrb);
		end
	end

	assign masterSystemReset = masterSystemReset_q;
	assign resetIrq = resetIrq_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign prdata = prdata_q;

	// checks start one edge after release, once the flops have left reset
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			resetLive_q <= 1'b0;
		end else begin
			resetLive_q <= 1'b1;
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n || !resetLive_q);

	master_on_a: assert property (|reqVec |=> masterSystemReset_q)
		else $error("master reset missing for active request");
	master_off_a: assert property (!(|reqVec) |=> !masterSystemReset_q)
		else $error("master reset without request");
	por_clears_a: assert property (reqVec.powerOnReset |=> cause_q == CAUSE_RST)
		else $error("power-on did not leave only bit 0");
	cause_capture_a: assert property (!reqVec.powerOnReset |=>
		((cause_q & $past(reqVec)) == $past(reqVec)))
		else $error("active source flag not set");
	write_nosys_a: assert property (wrCause && !(|reqVec) |=> !masterSystemReset_q)
		else $error("cause write raised master reset");
	cause_write_a: assert property (wrCause && !(|reqVec) |=>
		cause_q == $past(pwdata[NUM_SRC-1:0]))
		else $error("cause write not stored");
	sens_reset_a: assert property (masterSystemReset_q |=> sensScratch_q == SCRATCH_RST)
		else $error("sensitive register survived reset");
	keep_hold_a: assert property (masterSystemReset_q && !wrKeep |=> $stable(keepScratch_q))
		else $error("retained register lost value");
	multi_src_a: assert property ($countones(reqVec) > 1 && !reqVec.powerOnReset |=>
		(cause_q & $past(reqVec)) == $past(reqVec))
		else $error("simultaneous sources not all flagged");
	irq_level_a: assert property (|(evtStatus_q & evtMask_q) |=> resetIrq_q)
		else $error("interrupt missing");
	// apb handshake
	setup_idle_a: assert property (
		psel && !penable |=> !pready_q)
		else $error("ready during setup");
	access_ready_a: assert property (
		psel && penable && !pready_q |=> pready_q)
		else $error("ready not after one wait state");
	ready_pulse_a: assert property (
		pready_q |=> !pready_q)
		else $error("ready longer than one cycle");
	err_ready_a: assert property (
		pslverr_q |-> pready_q)
		else $error("error without ready");
	err_unmapped_a: assert property (
		psel && penable && !pready_q |=> pslverr_q == !$past(addrHit))
		else $error("error flag does not match decode");
	read_capture_a: assert property (
		psel && penable && !pready_q && !pwrite |=> prdata_q == $past(rdData))
		else $error("read data not captured");
	unmapped_zero_a: assert property (
		pslverr_q && !$past(pwrite) |-> prdata_q == 32'h0000_0000)
		else $error("unmapped read returned data");
	read_quiet_a: assert property (
		busDone && !pwrite && !(|reqVec) |=> $stable(cause_q) && $stable(evtMask_q))
		else $error("read changed a register");
	// cause flags
	cause_sticky_a: assert property (
		!wrCause && !reqVec.powerOnReset |=> (cause_q & $past(cause_q)) == $past(cause_q))
		else $error("cause flag lost without write");
	cause_idle_a: assert property (
		!wrCause && !(|reqVec) |=> $stable(cause_q))
		else $error("cause flag set without source");
	cause_software_a: assert property (
		wrCause && !reqVec.powerOnReset |=>
		(cause_q & ~$past(reqVec)) == ($past(pwdata[NUM_SRC-1:0]) & ~$past(reqVec)))
		else $error("software cause value not stored");
	por_flag_a: assert property (
		reqVec.powerOnReset |=> cause_q[POR_BIT])
		else $error("power-on flag not set");
	// event flags and interrupt
	evt_onset_a: assert property (
		|onsetVec |=> (evtStatus_q & $past(onsetVec)) == $past(onsetVec))
		else $error("event flag missed an onset");
	evt_sticky_a: assert property (
		!wrStatus |=> (evtStatus_q & $past(evtStatus_q)) == $past(evtStatus_q))
		else $error("event flag lost without write");
	evt_clear_a: assert property (
		wrStatus && !(|onsetVec) |=> (evtStatus_q & $past(pwdata[NUM_SRC-1:0])) == 7'h00)
		else $error("event flag not cleared by write");
	evt_quiet_a: assert property (
		!wrStatus && !(|onsetVec) |=> $stable(evtStatus_q))
		else $error("event flag set without onset");
	mask_write_a: assert property (
		wrMask |=> evtMask_q == $past(pwdata[NUM_SRC-1:0]))
		else $error("mask write not stored");
	mask_hold_a: assert property (
		!wrMask |=> $stable(evtMask_q))
		else $error("mask changed without write");
	irq_quiet_a: assert property (
		!(|(evtStatus_q & evtMask_q)) |=> !resetIrq_q)
		else $error("interrupt without unmasked flag");
	// pin synchroniser
	pin_set_a: assert property (
		pinSync_q[1] && pinSync_q[2] |=> pinActive_q)
		else $error("pin request not taken");
	pin_clear_a: assert property (
		!pinSync_q[1] && !pinSync_q[2] |=> !pinActive_q)
		else $error("pin request not released");
	pin_hold_a: assert property (
		pinSync_q[1] != pinSync_q[2] |=> $stable(pinActive_q))
		else $error("pin level taken before stages agree");
	// scratch registers
	sens_write_a: assert property (
		wrSens && !masterSystemReset_q |=>
		sensScratch_q == strbMerge($past(sensScratch_q), $past(pwdata), $past(pstrb)))
		else $error("sensitive scratch write not stored");
	keep_write_a: assert property (
		wrKeep |=>
		keepScratch_q == strbMerge($past(keepScratch_q), $past(pwdata), $past(pstrb)))
		else $error("retained scratch write not stored");
	keep_idle_a: assert property (
		!wrKeep |=> $stable(keepScratch_q))
		else $error("retained scratch changed without write");

	pin_reset_c: cover property (reqVec.externalClearPinReset ##1 masterSystemReset_q);
	multi_src_c: cover property ($countones(reqVec) > 1);
	sw_clear_c: cover property (wrCause && pwdata[NUM_SRC-1:0] == 7'h00);
	irq_c: cover property (resetIrq_q);
	evt_clear_c: cover property (wrStatus && (|evtStatus_q));
endmodule : reset_source_combiner
`default_nettype wire

// ### reset_source_model.sv
// Purpose: behavioural model of the reset sources around the combiner
// Assumes: bench commands one bit per source, power-on in bit 0
// Notes: pin is active low and idles high
`timescale 1ns/10ps
`default_nettype none
module reset_source_model
	import reset_combiner_pkg::*;
(
	// clock and commands
	input wire logic ref_clk,
	input wire logic [6:0] srcCmd,
	// source outputs
	output var onchipReq_s onchipReq,
	output var logic externalClearPin_n
);
	initial begin
		onchipReq = '0;
		externalClearPin_n = 1'b1;
	end
	always @(posedge ref_clk) begin
		onchipReq <= {srcCmd[6:3], srcCmd[1:0]};
		externalClearPin_n <= ~srcCmd[2];
	end
endmodule : reset_source_model
`default_nettype wire

// ### reset_source_combiner_tb_top.sv
// Purpose: self-checking bench for the reset source combiner
// Assumes: apb slave answers by pready, bench waits are bounded
// Notes: model tracks cause, event status and mask as integers
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_mismatch++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module reset_source_combiner_tb_top
	import reset_combiner_pkg::*;
;
	logic ref_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic [6:0] srcCmd = '0;
	logic pready, pslverr, masterSystemReset, resetIrq, perr, externalClearPin_n;
	onchipReq_s onchipReq;
	int n_mismatch = 0, tests_run = 0, cause, stat, mask, v;
	initial forever #5 ref_clk = ~ref_clk;
	reset_source_model i_src(.ref_clk(ref_clk), .srcCmd(srcCmd), .onchipReq(onchipReq),
		.externalClearPin_n(externalClearPin_n));
	reset_source_combiner i_dut(.ref_clk(ref_clk), .rst_n(rst_n), .onchipReq(onchipReq),
		.externalClearPin_n(externalClearPin_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .masterSystemReset(masterSystemReset),
		.resetIrq(resetIrq));
	task test_done;
		$display("mismatches=%0d comparisons=%0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : test_done
	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input int d,
		output logic [31:0] r);
		int k;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= 32'(d);
		@(posedge ref_clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge ref_clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		r = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			`CHK(pready, 1'b1)
			test_done;
		end
		@(posedge ref_clk);
	endtask : apb
	task automatic waitRst(input logic lvl);
		int k;
		k = 0;
		do begin
			@(posedge ref_clk);
			k++;
		end while (masterSystemReset !== lvl && k < 30);
		`CHK(masterSystemReset, lvl)
		if (masterSystemReset !== lvl) test_done;
	endtask : waitRst
	task automatic hit(input int bits);
		srcCmd <= 7'(bits);
		waitRst(1'b1);
		apb(1'b0, LIVE_REQ_OFS, 0, rd);
		`CHK(rd, 32'(bits))
		srcCmd <= '0;
		waitRst(1'b0);
		cause = bits[0] ? 1 : (cause | bits);
		stat |= bits;
		apb(1'b0, CAUSE_OFS, 0, rd);
		`CHK(rd, 32'(cause))
		apb(1'b0, EVT_STATUS_OFS, 0, rd);
		`CHK(rd, 32'(stat))
		`CHK(resetIrq, 1'((stat & mask) != 0))
	endtask : hit
	initial begin
		void'($urandom(32'ha3e1_7b28));
		repeat (6) @(posedge ref_clk);
		`CHK(masterSystemReset, 1'b1)
		rst_n <= 1'b1;
		@(posedge ref_clk);
		cause = 1;
		stat = 0;
		mask = 'h10;
		apb(1'b0, CAUSE_OFS, 0, rd);
		`CHK(rd, 32'h0000_0001)
		apb(1'b0, EVT_MASK_OFS, 0, rd);
		`CHK(rd, 32'h0000_0000)
		apb(1'b1, EVT_MASK_OFS, mask, rd);
		apb(1'b1, CAUSE_OFS, 0, rd);
		cause = 0;
		for (int i = 1; i < 7; i++) hit(1 << i);
		apb(1'b1, EVT_STATUS_OFS, 'h7F, rd);
		stat = 0;
		@(posedge ref_clk);
		`CHK(resetIrq, 1'b0)
		apb(1'b1, CAUSE_OFS, 0, rd);
		cause = 0;
		hit(($urandom & 'h7A) | 'h10);
		v = $urandom;
		apb(1'b1, SENS_SCRATCH_OFS, v, rd);
		apb(1'b1, KEEP_SCRATCH_OFS, ~v, rd);
		hit('h08);
		apb(1'b0, SENS_SCRATCH_OFS, 0, rd);
		`CHK(rd, 32'h0000_0000)
		apb(1'b0, KEEP_SCRATCH_OFS, 0, rd);
		`CHK(rd, 32'(~v))
		apb(1'b1, CAUSE_OFS, 'h7F, rd);
		repeat (4) begin
			@(posedge ref_clk);
			`CHK(masterSystemReset, 1'b0)
		end
		apb(1'b0, CAUSE_OFS, 0, rd);
		`CHK(rd, 32'h0000_007F)
		cause = 'h7F;
		hit('h01);
		apb(1'b0, 12'h020, 0, rd);
		`CHK(perr, 1'b1)
		`CHK(rd, 32'h0000_0000)
		test_done;
	end
endmodule : reset_source_combiner_tb_top
`default_nettype wire
